/* File: include/asi_pkg.sv */
// Shared constants and types of the asynchronous serial interface
package asi_pkg;

    // *************************************************
    // Register map
    // *************************************************
    localparam int ADR_W = 3;
    localparam logic [2:0] ADR_BAUD_HI = 3'h0;
    localparam logic [2:0] ADR_BAUD_LO = 3'h1;
    localparam logic [2:0] ADR_CTRL_ONE = 3'h2;
    localparam logic [2:0] ADR_CTRL_TWO = 3'h3;
    localparam logic [2:0] ADR_STAT_ONE = 3'h4;
    localparam logic [2:0] ADR_STAT_TWO = 3'h5;
    localparam logic [2:0] ADR_DATA_HI = 3'h6;
    localparam logic [2:0] ADR_DATA_LO = 3'h7;

    // *************************************************
    // Field positions and reset values
    // *************************************************
    localparam int C1_WORD9 = 0;
    localparam int C1_PAR_EN = 1;
    localparam int C1_PAR_ODD = 2;
    localparam int C2_BREAK = 0;
    localparam int C2_RX_ON = 2;
    localparam int C2_TX_ON = 3;
    localparam int C2_QUIET_IE = 4;
    localparam int C2_RX_IE = 5;
    localparam int C2_DONE_IE = 6;
    localparam int C2_HOLD_IE = 7;
    localparam int DH_RX8 = 7;
    localparam int DH_TX8 = 6;
    localparam int DIV_W = 13;
    localparam logic [12:0] BAUD_RST = 13'h0041;
    localparam logic [2:0] CTRL_ONE_RST = 3'h0;
    localparam logic [7:0] CTRL_TWO_RST = 8'h00;

    // *************************************************
    // Framing and oversampling
    // *************************************************
    localparam int FRAME_W = 12;
    localparam logic [3:0] BITS_NARROW = 4'h8;
    localparam logic [3:0] BITS_WIDE = 4'h9;
    localparam logic [3:0] FRAME_EXTRA = 4'h2;
    localparam logic [3:0] SMP_FIRST = 4'h7;
    localparam logic [3:0] SMP_MID = 4'h8;
    localparam logic [3:0] SMP_LAST = 4'h9;
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [7:0] QUIET_MAX = 8'hFF;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_START = 2'h1,
        RX_DATA = 2'h3,
        RX_STOP = 2'h2
    } asi_rx_state_t;

endpackage : asi_pkg

/* File: logic/asi_baud.sv */
// Baud prescaler giving sixteen ticks per bit time
`timescale 1ns/1ps
module asi_baud (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Divisor and tick
    input wire logic [asi_pkg::DIV_W-1:0] div_i,
    output logic tick_o
);
    import asi_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic half;
        logic tick;
    } asi_baud_st_t;

    asi_baud_st_t q, d;

    // Modulus counter, then halved: bit time is 32 * divisor clocks
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (div_i == '0) begin
            d.cnt = '0; // Zero divisor parks the generator
        end else if (q.cnt >= div_i - 13'h0001) begin
            d.cnt = '0;
            d.half = ~q.half;
            d.tick = q.half;
        end else begin
            d.cnt = q.cnt + 13'h0001;
        end
    end

    // State register
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;

endmodule : asi_baud

/* File: logic/asi_tx_shift.sv */
// Transmit shift register: sends a prepared frame, LSB first
`timescale 1ns/1ps
module asi_tx_shift (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Timing
    input wire logic tick_i,
    // Frame load
    input wire logic start_i,
    input wire logic [asi_pkg::FRAME_W-1:0] frame_i,
    input wire logic [3:0] nbits_i,
    // Line and status
    output logic line_o,
    output logic busy_o,
    output logic done_o
);
    import asi_pkg::*;

    typedef struct packed {
        logic [FRAME_W-1:0] sh;
        logic [3:0] left;
        logic [3:0] sub;
        logic busy;
        logic done;
        logic line;
    } asi_tx_st_t;

    asi_tx_st_t q, d;

    // Parallel load, then one bit per sixteen ticks
    always_comb begin
        d = q;
        d.done = 1'b0;
        if (!q.busy) begin
            d.line = 1'b1;
            if (start_i) begin
                d.sh = frame_i;
                d.left = nbits_i;
                d.sub = '0;
                d.busy = 1'b1;
                d.line = frame_i[0];
            end
        end else if (tick_i) begin
            d.sub = q.sub + 4'h1;
            if (q.sub == SUB_LAST) begin
                d.sh = {1'b1, q.sh[FRAME_W-1:1]};
                d.left = q.left - 4'h1;
                d.line = q.sh[1];
                if (q.left == 4'h1) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    d.line = 1'b1;
                end
            end
        end
    end

    // State register; only reset cuts a frame short
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
            q.line <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign line_o = q.line;
    assign busy_o = q.busy;
    assign done_o = q.done;

endmodule : asi_tx_shift

/* File: logic/asi_core.sv */
// Asynchronous serial interface: registers, transmit control and receiver
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module asi_core (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [asi_pkg::ADR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Serial line
    input wire logic rxd_i,
    output logic txd_o,
    output logic txd_sel_o,
    // Interrupt request
    output logic irq_o
);
    import asi_pkg::*;

    // *************************************************
    // State
    // *************************************************
    typedef struct packed {
        logic [4:0] baud_hi;
        logic [7:0] baud_lo;
        logic [2:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] rdata;
        logic t8;
        logic hold_valid;
        logic [8:0] hold_data;
        logic preamble;
        logic tx_holding_empty;
        logic tx_done;
        logic rx_holding_full;
        logic f_idle;
        logic f_over;
        logic rx_noise;
        logic rx_framing_err;
        logic rx_parity_err;
        logic tx_arm;
        logic rx_arm;
        logic [8:0] rx_holding_reg;
        logic [1:0] rx_sync;
        logic rx_prev;
        asi_rx_state_t rx_st;
        logic [3:0] sub;
        logic [3:0] bitcnt;
        logic [1:0] smp;
        logic [8:0] rx_sh;
        logic noise_acc;
        logic rx_busy_flag;
        logic [7:0] quiet;
    } asi_core_st_t;

    asi_core_st_t q, d;

    logic tick;
    logic tx_busy;
    logic tx_fin;
    logic tx_start;
    logic [FRAME_W-1:0] tx_frame;
    logic [3:0] tx_len;

    // *************************************************
    // Shared rate and transmit shifter
    // *************************************************
    // One generator feeds both directions
    asi_baud u_baud (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .div_i({q.baud_hi, q.baud_lo}),
        .tick_o(tick)
    );

    asi_tx_shift u_tx (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .tick_i(tick),
        .start_i(tx_start),
        .frame_i(tx_frame),
        .nbits_i(tx_len),
        .line_o(txd_o),
        .busy_o(tx_busy),
        .done_o(tx_fin)
    );

    // *************************************************
    // Next state
    // *************************************************
    always_comb begin
        logic word9;
        logic par_en;
        logic par_odd;
        logic tx_on;
        logic [3:0] nw;
        logic [3:0] nbits;
        logic [8:0] txw;
        logic [7:0] stat;
        logic line;
        logic maj;
        logic noisy;
        logic [8:0] word;
        logic pbit;
        logic pcalc;
        logic set_the;
        logic set_tdone;
        logic clr_tx;
        logic clr_rx;
        word9 = q.ctrl1[C1_WORD9];
        par_en = q.ctrl1[C1_PAR_EN];
        par_odd = q.ctrl1[C1_PAR_ODD];
        tx_on = q.ctrl2[C2_TX_ON];
        nw = word9 ? BITS_WIDE : BITS_NARROW;
        nbits = nw + FRAME_EXTRA;
        txw = '0;
        stat = '0;
        line = q.rx_sync[1];
        maj = 1'b0;
        noisy = 1'b0;
        word = '0;
        pbit = 1'b0;
        pcalc = 1'b0;
        set_the = 1'b0;
        set_tdone = 1'b0;
        clr_tx = 1'b0;
        clr_rx = 1'b0;
        d = q;

        // Transmit frame: start, data, stop; parity in top data slot
        txw = word9 ? q.hold_data : {1'b0, q.hold_data[7:0]};
        if (par_en && word9) begin
            txw[8] = (^q.hold_data[7:0]) ^ par_odd;
        end else if (par_en) begin
            txw[7] = (^q.hold_data[6:0]) ^ par_odd;
        end
        tx_frame = {2'b00, txw, 1'b0};
        tx_frame[nbits - 4'h1] = 1'b1;
        tx_len = nbits;
        tx_start = 1'b0;
        if (!tx_busy && tx_on && tick) begin
            tx_start = q.preamble | q.hold_valid | q.ctrl2[C2_BREAK];
            if (q.preamble) begin
                tx_frame = '1;
                d.preamble = 1'b0;
            end else if (q.hold_valid) begin
                d.hold_valid = 1'b0;
                set_the = 1'b1;
            end else if (q.ctrl2[C2_BREAK]) begin
                tx_frame = '0;
                tx_frame[nbits] = 1'b1;
                tx_len = nbits + 4'h1;
            end
        end

        // Line idle after the last frame, or shut down after it
        if (tx_fin && !(tx_on && (q.preamble | q.hold_valid | q.ctrl2[C2_BREAK]))) begin
            set_tdone = 1'b1;
            set_the = set_the | ~tx_on;
        end

        // Register reads answer one cycle later
        d.rdata = '0;
        stat[7] = q.tx_holding_empty;
        stat[6] = q.tx_done;
        stat[5] = q.rx_holding_full;
        stat[4] = q.f_idle;
        stat[3] = q.f_over;
        stat[2] = q.rx_noise;
        stat[1] = q.rx_framing_err;
        stat[0] = q.rx_parity_err;
        if (rd_i) begin
            if (addr_i == ADR_BAUD_HI) begin
                d.rdata = {3'h0, q.baud_hi};
            end else if (addr_i == ADR_BAUD_LO) begin
                d.rdata = q.baud_lo;
            end else if (addr_i == ADR_CTRL_ONE) begin
                d.rdata = {5'h00, q.ctrl1};
            end else if (addr_i == ADR_CTRL_TWO) begin
                d.rdata = q.ctrl2;
            end else if (addr_i == ADR_STAT_ONE) begin
                d.rdata = stat;
                d.tx_arm = stat[7] | stat[6];
                d.rx_arm = |stat[5:0];
            end else if (addr_i == ADR_STAT_TWO) begin
                d.rdata = {7'h00, q.rx_busy_flag};
            end else if (addr_i == ADR_DATA_HI) begin
                d.rdata[DH_RX8] = q.rx_holding_reg[8];
                d.rdata[DH_TX8] = q.t8;
            end else begin
                d.rdata = q.rx_holding_reg[7:0];
                clr_rx = q.rx_arm;
                d.rx_arm = 1'b0;
            end
        end

        // Register writes
        if (wr_i) begin
            if (addr_i == ADR_BAUD_HI) begin
                d.baud_hi = wdata_i[4:0];
            end else if (addr_i == ADR_BAUD_LO) begin
                d.baud_lo = wdata_i;
            end else if (addr_i == ADR_CTRL_ONE) begin
                d.ctrl1 = wdata_i[2:0];
            end else if (addr_i == ADR_CTRL_TWO) begin
                d.ctrl2 = wdata_i;
                if (wdata_i[C2_TX_ON] && !tx_on) begin
                    set_the = 1'b1;
                    set_tdone = 1'b1;
                    d.preamble = 1'b1;
                end else if (!wdata_i[C2_TX_ON] && tx_on) begin
                    d.hold_valid = 1'b0;
                    d.preamble = 1'b0;
                    set_the = set_the | ~tx_busy;
                    set_tdone = set_tdone | ~tx_busy;
                end
            end else if (addr_i == ADR_DATA_HI) begin
                d.t8 = wdata_i[DH_TX8];
            end else if (addr_i == ADR_DATA_LO) begin
                if (tx_on) begin
                    d.hold_valid = 1'b1;
                    d.hold_data = {q.t8, wdata_i};
                end
                clr_tx = q.tx_arm;
                d.tx_arm = 1'b0;
            end
        end

        // Transmit flags: a set in the same cycle beats the clear
        d.tx_holding_empty = (q.tx_holding_empty & ~clr_tx) | set_the;
        d.tx_done = (q.tx_done & ~clr_tx) | set_tdone;
        if (clr_rx) begin
            d.rx_holding_full = 1'b0;
            d.f_idle = 1'b0;
            d.f_over = 1'b0;
            d.rx_noise = 1'b0;
            d.rx_framing_err = 1'b0;
            d.rx_parity_err = 1'b0;
        end

        // *************************************************
        // Receiver
        // *************************************************
        // Two flops before any logic looks at the pin
        d.rx_sync = {q.rx_sync[0], rxd_i};
        d.rx_prev = line;

        // Quiet time counted in ticks; one frame of ones means idle
        if (!line) begin
            d.quiet = '0;
        end else if (tick && q.quiet != QUIET_MAX) begin
            d.quiet = q.quiet + 8'h01;
        end
        if (q.rx_busy_flag && q.rx_st == RX_IDLE && q.quiet >= {nbits, 4'h0}) begin
            d.f_idle = 1'b1;
            d.rx_busy_flag = 1'b0;
        end

        case (q.rx_st)
            RX_IDLE: begin
                // Falling edge realigns the bit clock
                if (q.ctrl2[C2_RX_ON] && q.rx_prev && !line) begin
                    d.rx_st = RX_START;
                    d.sub = '0;
                    d.bitcnt = '0;
                    d.noise_acc = 1'b0;
                    d.rx_busy_flag = 1'b1;
                end
            end
            default: begin
                if (tick) begin
                    d.sub = q.sub + 4'h1;
                    if (q.sub == SMP_FIRST) begin
                        d.smp[0] = line;
                    end
                    if (q.sub == SMP_MID) begin
                        d.smp[1] = line;
                    end
                    if (q.sub == SMP_LAST) begin
                        maj = (q.smp[0] & q.smp[1]) | (q.smp[0] & line) | (q.smp[1] & line);
                        noisy = (q.smp[0] != q.smp[1]) || (q.smp[1] != line);
                        d.noise_acc = q.noise_acc | noisy;
                        if (q.rx_st == RX_START && maj) begin
                            d.rx_st = RX_IDLE; // False start: glitch only
                        end else if (q.rx_st == RX_DATA) begin
                            d.rx_sh = {maj, q.rx_sh[8:1]};
                        end else if (q.rx_st == RX_STOP) begin
                            d.rx_st = RX_IDLE;
                            word = word9 ? q.rx_sh : {1'b0, q.rx_sh[8:1]};
                            pbit = word9 ? word[8] : word[7];
                            pcalc = (^(word & (word9 ? 9'h0FF : 9'h07F))) ^ par_odd;
                            if (q.rx_framing_err && !clr_rx) begin
                                d.rx_st = RX_IDLE;
                            end else if (q.rx_holding_full && !clr_rx) begin
                                d.f_over = 1'b1;
                            end else begin
                                d.rx_holding_reg = word;
                                d.rx_holding_full = 1'b1;
                                d.rx_noise = q.noise_acc | noisy;
                                d.rx_framing_err = ~maj;
                                d.rx_parity_err = par_en & (pcalc != pbit);
                            end
                        end
                    end
                    if (q.sub == SUB_LAST && d.rx_st == RX_START) begin
                        d.rx_st = RX_DATA;
                    end else if (q.sub == SUB_LAST && q.rx_st == RX_DATA) begin
                        d.bitcnt = q.bitcnt + 4'h1;
                        if (q.bitcnt == nw - 4'h1) begin
                            d.rx_st = RX_STOP;
                        end
                    end
                end
            end
        endcase
    end

    // *************************************************
    // Registers
    // *************************************************
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
            q.baud_hi <= BAUD_RST[12:8];
            q.baud_lo <= BAUD_RST[7:0];
            q.ctrl1 <= CTRL_ONE_RST;
            q.ctrl2 <= CTRL_TWO_RST;
            q.rx_sync <= 2'h3;
            q.rx_prev <= 1'b1;
            q.rx_st <= RX_IDLE;
        end else begin
            q <= d;
        end
    end

    // *************************************************
    // Outputs
    // *************************************************
    assign rdata_o = q.rdata;
    assign txd_sel_o = q.ctrl2[C2_TX_ON];

    // Level request from standing flags and their enables
    assign irq_o = (q.tx_holding_empty & q.ctrl2[C2_HOLD_IE])
        | (q.tx_done & q.ctrl2[C2_DONE_IE])
        | ((q.rx_holding_full | q.f_over) & q.ctrl2[C2_RX_IE])
        | (q.f_idle & q.ctrl2[C2_QUIET_IE]);

endmodule : asi_core

/* File: verif/asi_chk.sv */
// Concurrent checks on the ports of the serial interface core
`timescale 1ns/1ps
module asi_chk (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [asi_pkg::ADR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // Serial line and interrupt request
    input wire logic rxd_i,
    input wire logic txd_o,
    input wire logic txd_sel_o,
    input wire logic irq_o
);
    import asi_pkg::*;
    // ************************************
    // Shadow of written settings and low-run counter
    // ************************************
    logic [12:0] div_q;
    logic [7:0] ctl_q;
    int low_q;
    // Shadow copies let the checks tie outputs to what software wrote
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_q <= BAUD_RST;
            ctl_q <= CTRL_TWO_RST;
            low_q <= 0;
        end else begin
            if (wr_i && addr_i == ADR_BAUD_HI) div_q[12:8] <= wdata_i[4:0];
            if (wr_i && addr_i == ADR_BAUD_LO) div_q[7:0] <= wdata_i;
            if (wr_i && addr_i == ADR_CTRL_TWO) ctl_q <= wdata_i;
            low_q <= txd_o ? 0 : low_q + 1;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_rd(logic [2:0] a);
        rd_i && addr_i == a;
    endsequence
    sequence s_wr(logic [2:0] a);
        wr_i && addr_i == a;
    endsequence
    a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    a_baud_lo_back: assert property (s_rd(ADR_BAUD_LO) |=> rdata_o == div_q[7:0])
        else $error("baud low readback wrong");
    a_baud_hi_back: assert property (s_rd(ADR_BAUD_HI) |=> rdata_o[4:0] == div_q[12:8])
        else $error("baud high readback wrong");
    a_ctrl_two_back: assert property (s_rd(ADR_CTRL_TWO) |=> rdata_o[7:2] == ctl_q[7:2])
        else $error("control two readback wrong");
    a_pin_sel_follow: assert property (s_wr(ADR_CTRL_TWO) |=> txd_sel_o == $past(wdata_i[C2_TX_ON]))
        else $error("pin select does not follow transmitter enable");
    a_pin_sel_hold: assert property (!(wr_i && addr_i == ADR_CTRL_TWO) |=> $stable(txd_sel_o))
        else $error("pin select moved without a control write");
    a_bit_time_grid: assert property ($rose(txd_o) |-> low_q % (32 * int'(div_q)) == 0)
        else $error("low run not a whole number of bit times");
    a_low_run_max: assert property (low_q <= 11 * 32 * int'(div_q))
        else $error("line held low longer than a frame");
    a_irq_no_enable: assert property (ctl_q[7:4] == 4'h0 |-> !irq_o)
        else $error("interrupt raised with all enables off");
endmodule : asi_chk

bind asi_core asi_chk u_asi_chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o), .txd_sel_o(txd_sel_o),
    .irq_o(irq_o));

/* File: verif/asi_remote.sv */
// Behavioural remote serial device facing the core's line pins
`timescale 1ns/1ps
module asi_remote (
    // Clock
    input wire logic mclk_i,
    // Line
    input wire logic txd_i,
    output logic rxd_o
);
    // ************************************
    // Receiver and sender, 32 clocks per bit (divisor 1)
    // ************************************
    localparam int BIT_CLK = 32;
    logic [7:0] got_q;
    logic stop_q;
    int cnt_q;
    initial begin
        rxd_o = 1'b1;
        cnt_q = 0;
        got_q = 8'h00;
        stop_q = 1'b0;
    end
    // Centre sampling after each falling start edge, LSB first
    always @(negedge txd_i) begin
        repeat (BIT_CLK / 2) @(posedge mclk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLK) @(posedge mclk_i);
            got_q[i] = txd_i;
        end
        repeat (BIT_CLK) @(posedge mclk_i);
        stop_q = txd_i;
        cnt_q++;
    end
    // One frame; a short spike in bit 0 hits only one of three samples
    task automatic send(input logic [8:0] w, input int nbits, input logic stop, input logic noisy);
        rxd_o <= 1'b0;
        repeat (BIT_CLK) @(posedge mclk_i);
        for (int i = 0; i < nbits; i++) begin
            rxd_o <= w[i];
            if (noisy && i == 0) begin
                repeat (19) @(posedge mclk_i);
                rxd_o <= ~w[0];
                repeat (2) @(posedge mclk_i);
                rxd_o <= w[0];
                repeat (BIT_CLK - 21) @(posedge mclk_i);
            end else begin
                repeat (BIT_CLK) @(posedge mclk_i);
            end
        end
        rxd_o <= stop;
        repeat (BIT_CLK) @(posedge mclk_i);
        rxd_o <= 1'b1;
        repeat (BIT_CLK) @(posedge mclk_i);
    endtask : send
endmodule : asi_remote

/* File: verif/test_async_serial_interface.sv */
// Self-checking bench of the serial interface core against a remote device
`timescale 1ns/1ps
module test_async_serial_interface;
    import asi_pkg::*;
    // ************************************
    // Signals, instances, clock
    // ************************************
    logic mclk_i, nrst_i, wr_i, rd_i, rxd_i, txd_o, txd_sel_o, irq_o;
    logic [ADR_W-1:0] addr_i;
    logic [7:0] wdata_i, rdata_o, v;
    int miscompares, num_checks;
    asi_core u_asi_core (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o), .txd_sel_o(txd_sel_o), .irq_o(irq_o));
    asi_remote u_asi_remote (.mclk_i(mclk_i), .txd_i(txd_o), .rxd_o(rxd_i));
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask : chk
    // One-cycle strobes, changed just after the rising edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        v = rdata_o;
    endtask : rd
    // Poll status until all bits of m are set, bounded
    task automatic wait_stat(input logic [7:0] m);
        int k;
        k = 0;
        do begin
            rd(ADR_STAT_ONE);
            k++;
        end while ((v & m) !== m && k < 600);
        chk("status flags", m, v & m);
        if ((v & m) !== m) final_report();
    endtask : wait_stat
    task automatic wait_tx(input int n);
        int k;
        k = 0;
        while (u_asi_remote.cnt_q != n && k < 3000) begin
            @(posedge mclk_i);
            k++;
        end
        if (u_asi_remote.cnt_q != n) begin
            miscompares++;
            final_report();
        end
    endtask : wait_tx
    // ************************************
    // Scenarios
    // ************************************
    task automatic t_tx();
        wr(ADR_BAUD_HI, 8'h00);
        wr(ADR_BAUD_LO, 8'h01);
        rd(ADR_BAUD_LO);
        chk("baud low", 8'h01, v);
        wr(ADR_CTRL_TWO, 8'h0C);
        rd(ADR_STAT_ONE);
        chk("tx flags on enable", 8'hC0, v & 8'hC0);
        wr(ADR_DATA_LO, 8'hA5);
        wait_stat(8'h80);
        wr(ADR_DATA_LO, 8'h3C);
        wait_tx(1);
        chk("first char", 8'hA5, u_asi_remote.got_q);
        chk("stop bit", 8'h01, {7'h00, u_asi_remote.stop_q});
        wait_tx(2);
        chk("second char", 8'h3C, u_asi_remote.got_q);
        wait_stat(8'hC0);
    endtask : t_tx
    task automatic t_tx_off();
        wr(ADR_DATA_LO, 8'h11);
        wr(ADR_DATA_LO, 8'h22);
        wr(ADR_CTRL_TWO, 8'h04);
        @(negedge mclk_i);
        chk("pin select off", 8'h00, {7'h00, txd_sel_o});
        wait_tx(3);
        chk("char finished", 8'h11, u_asi_remote.got_q);
        repeat (900) @(posedge mclk_i);
        chk("queue dropped", 8'h03, 8'(u_asi_remote.cnt_q));
        wait_stat(8'hC0);
        wr(ADR_CTRL_TWO, 8'h09);
        wait_tx(4);
        chk("break data", 8'h00, u_asi_remote.got_q);
        chk("break stop", 8'h00, {7'h00, u_asi_remote.stop_q});
        wr(ADR_CTRL_TWO, 8'h04);
    endtask : t_tx_off
    task automatic t_rx();
        wr(ADR_CTRL_TWO, 8'h24);
        u_asi_remote.send(9'h05A, 8, 1'b1, 1'b0);
        wait_stat(8'h20);
        chk("irq on full", 8'h01, {7'h00, irq_o});
        rd(ADR_DATA_LO);
        chk("rx data", 8'h5A, v);
        rd(ADR_STAT_ONE);
        chk("full cleared", 8'h00, v & 8'h20);
        wait_stat(8'h10);
        rd(ADR_STAT_TWO);
        chk("busy cleared", 8'h00, v);
        rd(ADR_DATA_LO);
        repeat (400) @(posedge mclk_i);
        rd(ADR_STAT_ONE);
        chk("idle once", 8'h00, v & 8'h10);
    endtask : t_rx
    task automatic t_rx_errors();
        u_asi_remote.send(9'h0C3, 8, 1'b1, 1'b0);
        u_asi_remote.send(9'h03C, 8, 1'b1, 1'b0);
        wait_stat(8'h28);
        rd(ADR_DATA_LO);
        chk("held data kept", 8'hC3, v);
        u_asi_remote.send(9'h055, 8, 1'b0, 1'b0);
        wait_stat(8'h22);
        u_asi_remote.send(9'h00F, 8, 1'b1, 1'b0);
        rd(ADR_STAT_ONE);
        chk("framing blocks", 8'h00, v & 8'h08);
        rd(ADR_DATA_LO);
        u_asi_remote.send(9'h0F0, 8, 1'b1, 1'b1);
        wait_stat(8'h24);
        rd(ADR_DATA_LO);
        chk("noisy data", 8'hF0, v);
        wr(ADR_CTRL_ONE, 8'h02);
        u_asi_remote.send(9'h001, 8, 1'b1, 1'b0);
        wait_stat(8'h21);
        rd(ADR_DATA_LO);
        u_asi_remote.send(9'h081, 8, 1'b1, 1'b0);
        wait_stat(8'h20);
        chk("parity good", 8'h00, v & 8'h01);
        rd(ADR_DATA_LO);
        wr(ADR_CTRL_ONE, 8'h01);
        u_asi_remote.send(9'h1A5, 9, 1'b1, 1'b0);
        wait_stat(8'h20);
        rd(ADR_DATA_HI);
        chk("ninth bit", 8'h80, v & 8'h80);
    endtask : t_rx_errors
    initial begin
        miscompares = 0;
        num_checks = 0;
        nrst_i = 1'b0;
        addr_i = '0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        repeat (5) @(posedge mclk_i);
        nrst_i <= 1'b1;
        rd(ADR_BAUD_LO);
        chk("baud reset", 8'h41, v);
        t_tx();
        t_tx_off();
        t_rx();
        t_rx_errors();
        final_report();
    end
endmodule : test_async_serial_interface
